// ---- intfr_cpu_model.sv ----
// Purpose: CPU core that acknowledges pending requests
// Assumes: Enabled by the bench
// Notes: Delay sets prompt or slow answers
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [3:0] delay,
  input wire intfr_pkg::intfr_pend_type intr_pend,
  output logic cpu_ack,
  output logic [`INTFR_IDX_W-1:0] cpu_ack_index
);
  logic [3:0] cnt;
  logic [1:0] hold;
  // Hold lets the cleared flag reach intr_pend, so one request is not acked twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_ack_index <= 5'h00;
      cnt <= 4'h0;
      hold <= 2'h0;
    end else begin
      cpu_ack <= 1'b0;
      if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end else if (enable && intr_pend.valid) begin
        if (cnt == delay) begin
          cpu_ack <= 1'b1;
          cpu_ack_index <= intr_pend.index;
          cnt <= 4'h0;
          hold <= 2'h3;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ---- intfr_defs.svh ----
// Purpose: Shared constants of the interrupt flag register block
// Assumes: Included by its bare name; definitions only
// Notes: Flag bit n of the 32-bit flag vector is the source of default priority n
`ifndef INTFR_DEFS_SVH
`define INTFR_DEFS_SVH

`define INTFR_NUM_SRC 29
`define INTFR_IDX_W 5
`define INTFR_NUM_EXT 6
`define INTFR_EXT_LSB 1
`define INTFR_SER_BIT 10
`define INTFR_TM51_BIT 19
`define INTFR_RMT_BIT 27
`define INTFR_NUM_RMT 4

`define INTFR_REQ_VALID 32'h1FFF_FFFF
`define INTFR_REQ_RST 16'h0000
`define INTFR_MASK_RST 16'hFFFF
`define INTFR_PRIO_RST 16'hFFFF
`define INTFR_EDGE_RST 6'h00
`define INTFR_EV_RST 3'h0
`define INTFR_EV_MASK_RST 3'h7

`define INTFR_OFS_REQ0 8'h00
`define INTFR_OFS_REQ1 8'h04
`define INTFR_OFS_MASK0 8'h08
`define INTFR_OFS_MASK1 8'h0C
`define INTFR_OFS_PRIO0 8'h10
`define INTFR_OFS_PRIO1 8'h14
`define INTFR_OFS_RISE 8'h18
`define INTFR_OFS_FALL 8'h1C
`define INTFR_OFS_BITOP 8'h20
`define INTFR_OFS_PEND 8'h24
`define INTFR_OFS_EVST 8'h28
`define INTFR_OFS_EVMSK 8'h2C

`define INTFR_BITOP_VAL 8
`define INTFR_PEND_VALID 0
`define INTFR_PEND_IDX_LSB 8
`define INTFR_PEND_LEVEL 16

`define INTFR_EV_W 3
`define INTFR_EV_RAISE 0
`define INTFR_EV_ACK 1
`define INTFR_EV_STRAY 2

`endif

// ---- intfr_edge_detect.sv ----
// Purpose: Edge detection on the external interrupt pins
// Assumes: Pins are asynchronous to pclk
// Notes: A pin change is seen after two clock edges, even a one-cycle pulse
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [`INTFR_NUM_EXT-1:0] pins,
  input wire logic [`INTFR_NUM_EXT-1:0] rise_en,
  input wire logic [`INTFR_NUM_EXT-1:0] fall_en,
  output logic [`INTFR_NUM_EXT-1:0] edge_pulse
);

  logic [`INTFR_NUM_EXT-1:0] sync1;
  logic [`INTFR_NUM_EXT-1:0] sync2;
  logic [`INTFR_NUM_EXT-1:0] last;
  logic [`INTFR_NUM_EXT-1:0] next_sync1;
  logic [`INTFR_NUM_EXT-1:0] next_sync2;
  logic [`INTFR_NUM_EXT-1:0] next_last;

  always_comb begin
    next_sync1 = sync1;
    next_sync2 = sync2;
    next_last = last;
    if (ce) begin
      next_sync1 = pins;
      next_sync2 = sync1;
      next_last = sync2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `INTFR_EDGE_RST;
      sync2 <= `INTFR_EDGE_RST;
      last <= `INTFR_EDGE_RST;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      last <= next_last;
    end
  end

  // Only the second stage and later are looked at
  assign edge_pulse = ((sync2 & ~last & rise_en) | (~sync2 & last & fall_en))
    & {`INTFR_NUM_EXT{ce}}; // (RULE14)

endmodule

// ---- intfr_pkg.sv ----
// Purpose: Types of the interrupt flag register block
// Assumes: intfr_defs.svh supplies the widths
// Notes: Used only with package-qualified names
`include "intfr_defs.svh"

package intfr_pkg;

  typedef enum logic {
    INTFR_BUS_IDLE,
    INTFR_BUS_ANS
  } intfr_bus_state_type;

  typedef struct packed {
    logic valid;
    logic level;
    logic [`INTFR_IDX_W-1:0] index;
  } intfr_pend_type;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] strb;
  } intfr_apb_req_type;

endpackage

// ---- intfr_prio_arb.sv ----
// Purpose: Picks the request to be serviced next
// Assumes: Inputs are unmasked requests and their priority flags
// Notes: Priority flag low means the high level group
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_prio_arb (
  input wire logic [`INTFR_NUM_SRC-1:0] cand,
  input wire logic [`INTFR_NUM_SRC-1:0] prio,
  output intfr_pkg::intfr_pend_type pick
);

  logic [`INTFR_NUM_SRC-1:0] hi_grp;
  logic [`INTFR_NUM_SRC-1:0] lo_grp;

  // Lowest index wins, which is the fixed default order
  function automatic logic [`INTFR_IDX_W-1:0] first_set(input logic [`INTFR_NUM_SRC-1:0] v);
    first_set = '0;
    for (int i = `INTFR_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = `INTFR_IDX_W'(i);
      end
    end
  endfunction

  always_comb begin
    hi_grp = cand & ~prio; // (RULE8) (RULE11)
    lo_grp = cand & prio;
    pick = '0;
    if (|hi_grp) begin
      pick.valid = 1'b1;
      pick.level = 1'b0;
      pick.index = first_set(hi_grp); // (RULE17)
    end else if (|lo_grp) begin
      pick.valid = 1'b1;
      pick.level = 1'b1;
      pick.index = first_set(lo_grp); // (RULE17)
    end
  end

endmodule

// ---- intfr_top.sv ----
// Purpose: Interrupt request, mask and priority flag registers with APB access
// Assumes: Sources and acknowledge are single-cycle pulses on pclk
// Notes: One wait state on every APB access
// What this block does
// (RULE1) A source request or a software write of one sets its request flag.
// (RULE2) CPU acknowledge clears the acknowledged request flag before servicing.
// (RULE3) Reset clears all four request flag bytes to zero.
// (RULE4) Flag bytes take single-bit and whole-byte writes; bit writes touch one flag. Here mask and priority flags take byte writes only.
// (RULE5) Low and high request bytes of each bank also form one 16-bit register.
// (RULE6) Clocked serial end or async transmit end sets bank0 high bit 2.
// (RULE7) Bank0 high mask bit 2 masks both shared serial sources.
// (RULE8) Bank0 high priority bit 2 sets the level of both serial sources.
// (RULE9) Any of the four remote-controller sources sets bank1 high bit 3.
// (RULE10) Bank1 high mask bit 3 masks all four remote sources.
// (RULE11) Bank1 high priority bit 3 sets one level for all remote sources.
// (RULE12) Each source owns a request, mask and priority flag in its banks.
// (RULE13) In carrier mode the timer51 flag follows the carrier timing signal.
// (RULE14) Separate rising and falling edge enables select external pin edges.
// (RULE15) Mask flag one blocks servicing, zero allows it.
// (RULE16) Reset sets all four mask flag bytes to all ones.
// (RULE17) Simultaneous requests are taken in fixed order, index 0 first.
// (RULE18) Bits 5 to 7 of bank1 high request byte stay zero.
// (RULE19) A request in the same cycle as a clear leaves the flag set.
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`INTFR_NUM_SRC-1:0] periph_req,
  input wire logic [`INTFR_NUM_EXT-1:0] ext_pin,
  input wire logic clocked_serial_end_irq,
  input wire logic async_tx_end_irq,
  input wire logic remote_rx_error_irq,
  input wire logic remote_guide_pulse_irq,
  input wire logic remote_rx_done_irq,
  input wire logic remote_shift_read_irq,
  input wire logic timer51_match_irq,
  input wire logic carrier_timing_signal,
  input wire logic carrier_mode,
  input wire logic cpu_ack,
  input wire logic [`INTFR_IDX_W-1:0] cpu_ack_index,
  output intfr_pkg::intfr_pend_type intr_pend,
  output logic irq
);

  intfr_pkg::intfr_bus_state_type bus_state;
  intfr_pkg::intfr_bus_state_type next_bus_state;
  intfr_pkg::intfr_apb_req_type apb;
  intfr_pkg::intfr_pend_type pick;
  intfr_pkg::intfr_pend_type next_intr_pend;

  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] read_data;
  logic mapped;
  logic wr_commit;
  logic rd_take;

  logic [31:0] req;
  logic [31:0] mask;
  logic [31:0] prio;
  logic [31:0] next_req;
  logic [31:0] next_mask;
  logic [31:0] next_prio;
  logic [31:0] set_vec;
  logic [`INTFR_NUM_EXT-1:0] rise_en;
  logic [`INTFR_NUM_EXT-1:0] fall_en;
  logic [`INTFR_NUM_EXT-1:0] next_rise_en;
  logic [`INTFR_NUM_EXT-1:0] next_fall_en;
  logic [`INTFR_NUM_EXT-1:0] ext_pulse;
  logic [`INTFR_NUM_RMT-1:0] remote_src;

  logic [`INTFR_EV_W-1:0] ev_stat;
  logic [`INTFR_EV_W-1:0] ev_mask;
  logic [`INTFR_EV_W-1:0] next_ev_stat;
  logic [`INTFR_EV_W-1:0] next_ev_mask;
  logic [`INTFR_EV_W-1:0] ev_set;
  logic next_irq;

  // Byte lanes of a 16-bit flag pair; a lane left out keeps its flags
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign apb = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};

  // Bus slave: first access cycle latches read data, second answers
  assign rd_take = ce && psel && penable && (bus_state == intfr_pkg::INTFR_BUS_IDLE);
  assign wr_commit = ce && psel && penable && apb.write && mapped
    && (bus_state == intfr_pkg::INTFR_BUS_ANS);

  always_comb begin
    mapped = hit(apb.addr, `INTFR_OFS_REQ0) || hit(apb.addr, `INTFR_OFS_REQ1)
      || hit(apb.addr, `INTFR_OFS_MASK0) || hit(apb.addr, `INTFR_OFS_MASK1)
      || hit(apb.addr, `INTFR_OFS_PRIO0) || hit(apb.addr, `INTFR_OFS_PRIO1)
      || hit(apb.addr, `INTFR_OFS_RISE) || hit(apb.addr, `INTFR_OFS_FALL)
      || hit(apb.addr, `INTFR_OFS_BITOP) || hit(apb.addr, `INTFR_OFS_PEND)
      || hit(apb.addr, `INTFR_OFS_EVST) || hit(apb.addr, `INTFR_OFS_EVMSK);
  end

  always_comb begin
    read_data = '0;
    unique case (apb.addr)
      `INTFR_OFS_REQ0: read_data[15:0] = req[15:0]; // (RULE5)
      `INTFR_OFS_REQ1: read_data[15:0] = req[31:16]; // (RULE5)
      `INTFR_OFS_MASK0: read_data[15:0] = mask[15:0];
      `INTFR_OFS_MASK1: read_data[15:0] = mask[31:16];
      `INTFR_OFS_PRIO0: read_data[15:0] = prio[15:0];
      `INTFR_OFS_PRIO1: read_data[15:0] = prio[31:16];
      `INTFR_OFS_RISE: read_data[`INTFR_NUM_EXT-1:0] = rise_en;
      `INTFR_OFS_FALL: read_data[`INTFR_NUM_EXT-1:0] = fall_en;
      `INTFR_OFS_PEND: begin
        read_data[`INTFR_PEND_VALID] = intr_pend.valid;
        read_data[`INTFR_PEND_IDX_LSB +: `INTFR_IDX_W] = intr_pend.index;
        read_data[`INTFR_PEND_LEVEL] = intr_pend.level;
      end
      `INTFR_OFS_EVST: read_data[`INTFR_EV_W-1:0] = ev_stat;
      `INTFR_OFS_EVMSK: read_data[`INTFR_EV_W-1:0] = ev_mask;
      default: read_data = '0;
    endcase
  end

  always_comb begin
    next_bus_state = bus_state;
    next_prdata = prdata;
    next_pready = pready;
    next_pslverr = pslverr;
    if (ce) begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_bus_state = intfr_pkg::INTFR_BUS_IDLE;
      if (rd_take) begin
        next_bus_state = intfr_pkg::INTFR_BUS_ANS;
        next_pready = 1'b1;
        next_pslverr = !mapped;
        next_prdata = apb.write ? 32'h0000_0000 : read_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= intfr_pkg::INTFR_BUS_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  intfr_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pins(ext_pin),
    .rise_en(rise_en),
    .fall_en(fall_en),
    .edge_pulse(ext_pulse)
  );

  assign remote_src = {remote_shift_read_irq, remote_rx_done_irq,
    remote_guide_pulse_irq, remote_rx_error_irq};

  // Hardware set vector; shared bits override their periph_req positions
  always_comb begin
    set_vec = '0;
    set_vec[`INTFR_NUM_SRC-1:0] = periph_req; // (RULE1) (RULE12)
    set_vec[`INTFR_EXT_LSB +: `INTFR_NUM_EXT] = ext_pulse; // (RULE14)
    set_vec[`INTFR_SER_BIT] = clocked_serial_end_irq | async_tx_end_irq; // (RULE6)
    set_vec[`INTFR_RMT_BIT] = |remote_src; // (RULE9)
    set_vec[`INTFR_TM51_BIT] = carrier_mode ? carrier_timing_signal : timer51_match_irq; // (RULE13)
  end

  // Flag registers
  always_comb begin
    next_req = req;
    next_mask = mask;
    next_prio = prio;
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    if (ce) begin
      if (wr_commit) begin
        unique case (apb.addr)
          `INTFR_OFS_REQ0: next_req[15:0] = merge16(req[15:0], apb.wdata[15:0], apb.strb[1:0]); // (RULE4) (RULE5)
          `INTFR_OFS_REQ1: next_req[31:16] = merge16(req[31:16], apb.wdata[15:0], apb.strb[1:0]); // (RULE4) (RULE5)
          `INTFR_OFS_MASK0: next_mask[15:0] = merge16(mask[15:0], apb.wdata[15:0], apb.strb[1:0]);
          `INTFR_OFS_MASK1: next_mask[31:16] = merge16(mask[31:16], apb.wdata[15:0], apb.strb[1:0]);
          `INTFR_OFS_PRIO0: next_prio[15:0] = merge16(prio[15:0], apb.wdata[15:0], apb.strb[1:0]);
          `INTFR_OFS_PRIO1: next_prio[31:16] = merge16(prio[31:16], apb.wdata[15:0], apb.strb[1:0]);
          `INTFR_OFS_RISE: begin
            if (apb.strb[0]) begin
              next_rise_en = apb.wdata[`INTFR_NUM_EXT-1:0]; // (RULE14)
            end
          end
          `INTFR_OFS_FALL: begin
            if (apb.strb[0]) begin
              next_fall_en = apb.wdata[`INTFR_NUM_EXT-1:0]; // (RULE14)
            end
          end
          `INTFR_OFS_BITOP: begin
            if (apb.strb[0]) begin
              next_req[apb.wdata[`INTFR_IDX_W-1:0]] = apb.wdata[`INTFR_BITOP_VAL]; // (RULE4)
            end
          end
          default: begin
          end
        endcase
      end
      if (cpu_ack) begin
        next_req[cpu_ack_index] = 1'b0; // (RULE2)
      end
      // Set applied last so a same-cycle clear never loses a request
      next_req = next_req | set_vec; // (RULE19) (RULE1)
      next_req = next_req & `INTFR_REQ_VALID; // (RULE18)
      // Unused priority bits are forced to zero; unused mask bits take what software writes
      next_prio = next_prio & `INTFR_REQ_VALID;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= {`INTFR_REQ_RST, `INTFR_REQ_RST}; // (RULE3)
      mask <= {`INTFR_MASK_RST, `INTFR_MASK_RST}; // (RULE16)
      prio <= {`INTFR_PRIO_RST, `INTFR_PRIO_RST} & `INTFR_REQ_VALID;
      rise_en <= `INTFR_EDGE_RST;
      fall_en <= `INTFR_EDGE_RST;
    end else begin
      req <= next_req;
      mask <= next_mask;
      prio <= next_prio;
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
    end
  end

  // Shared bits need no extra logic: one flag, one mask, one priority each
  intfr_prio_arb u_arb (
    .cand(req[`INTFR_NUM_SRC-1:0] & ~mask[`INTFR_NUM_SRC-1:0]), // (RULE15) (RULE7) (RULE10)
    .prio(prio[`INTFR_NUM_SRC-1:0]),
    .pick(pick)
  );

  // Event status, write one to clear, hardware set wins
  always_comb begin
    ev_set = '0;
    ev_set[`INTFR_EV_RAISE] = pick.valid && !intr_pend.valid;
    ev_set[`INTFR_EV_ACK] = cpu_ack;
    ev_set[`INTFR_EV_STRAY] = cpu_ack && !req[cpu_ack_index];
    next_ev_stat = ev_stat;
    next_ev_mask = ev_mask;
    next_intr_pend = intr_pend;
    next_irq = irq;
    if (ce) begin
      if (wr_commit && hit(apb.addr, `INTFR_OFS_EVST) && apb.strb[0]) begin
        next_ev_stat = ev_stat & ~apb.wdata[`INTFR_EV_W-1:0];
      end
      if (wr_commit && hit(apb.addr, `INTFR_OFS_EVMSK) && apb.strb[0]) begin
        next_ev_mask = apb.wdata[`INTFR_EV_W-1:0];
      end
      next_ev_stat = next_ev_stat | ev_set;
      next_intr_pend = pick;
      next_irq = |(next_ev_stat & ~next_ev_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat <= `INTFR_EV_RST;
      ev_mask <= `INTFR_EV_MASK_RST;
      intr_pend <= '0;
      irq <= 1'b0;
    end else begin
      ev_stat <= next_ev_stat;
      ev_mask <= next_ev_mask;
      intr_pend <= next_intr_pend;
      irq <= next_irq;
    end
  end

endmodule

// ---- intfr_top_bench.sv ----
// Purpose: Self-checking bench of the flag block
// Assumes: ce high except in the freeze test
// Notes: One task per scenario
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [36:0] ev = 37'h0;
  logic [5:0] ext_pin = 6'h00;
  logic carrier_mode = 1'b0;
  logic ce = 1'b1;
  logic cpu_en = 1'b0;
  logic [3:0] cpu_dly = 4'h5;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_ack;
  logic [4:0] cpu_ack_index;
  intfr_pkg::intfr_pend_type intr_pend;
  logic irq;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;

  intfr_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_req(ev[28:0]),
    .ext_pin(ext_pin), .clocked_serial_end_irq(ev[29]), .async_tx_end_irq(ev[30]),
    .remote_rx_error_irq(ev[31]), .remote_guide_pulse_irq(ev[32]),
    .remote_rx_done_irq(ev[33]), .remote_shift_read_irq(ev[34]),
    .timer51_match_irq(ev[35]), .carrier_timing_signal(ev[36]),
    .carrier_mode(carrier_mode), .cpu_ack(cpu_ack), .cpu_ack_index(cpu_ack_index),
    .intr_pend(intr_pend), .irq(irq));

  intfr_cpu_model cpu (.pclk(pclk), .presetn(presetn), .enable(cpu_en), .delay(cpu_dly),
    .intr_pend(intr_pend), .cpu_ack(cpu_ack), .cpu_ack_index(cpu_ack_index));

  initial begin
    forever #2 pclk = ~pclk;
  end

  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Slow runaway guard; the whole run needs under 2000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk(r, x);
  endtask

  task pulse(input int i);
    @(posedge pclk);
    ev <= 37'h1 << i;
    @(posedge pclk);
    ev <= 37'h0;
  endtask

  task t_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'hFFFF);
    rd(8'h0C, 32'hFFFF);
    apb(8'h30, 1'b0, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    $display("done reset");
  endtask

  task t_src;
    int p[10] = '{29, 30, 31, 32, 33, 34, 35, 36, 0, 28};
    int f[10] = '{10, 10, 27, 27, 27, 27, 19, 19, 0, 28};
    for (int i = 0; i < 10; i++) begin
      carrier_mode <= (i == 7);
      pulse(p[i]);
      rd(8'(f[i] / 16 * 4), 32'h1 << (f[i] % 16));
      wr(8'(f[i] / 16 * 4), 32'h0, 4'h3);
      rd(8'(f[i] / 16 * 4), 32'h0);
    end
    $display("done sources");
  endtask

  task t_bits;
    wr(8'h00, 32'hF0F0, 4'h1);
    rd(8'h00, 32'h00F0);
    wr(8'h00, 32'h0F0F, 4'h2);
    rd(8'h00, 32'h0FF0);
    wr(8'h20, 32'h0100, 4'h1);
    wr(8'h20, 32'h0004, 4'h1);
    rd(8'h00, 32'h0FE1);
    wr(8'h04, 32'hFFFF, 4'h3);
    rd(8'h04, 32'h1FFF);
    wr(8'h00, 32'h0, 4'h3);
    wr(8'h04, 32'h0, 4'h3);
    $display("done bits");
  endtask

  task t_pend;
    wr(8'h00, 32'h0500, 4'h3);
    chk({25'h0, intr_pend}, 32'h0);
    wr(8'h08, 32'hFAFF, 4'h3);
    repeat (2) @(posedge pclk);
    chk({25'h0, intr_pend}, 32'h68);
    wr(8'h10, 32'hFBFF, 4'h3);
    repeat (2) @(posedge pclk);
    chk({25'h0, intr_pend}, 32'h4A);
    rd(8'h24, 32'h0000_0A01);
    cpu_en <= 1'b1;
    repeat (40) @(posedge pclk);
    chk({25'h0, intr_pend}, 32'h0);
    rd(8'h00, 32'h0);
    cpu_en <= 1'b0;
    wr(8'h08, 32'hFFFF, 4'h3);
    wr(8'h10, 32'hFFFF, 4'h3);
    $display("done pending");
  endtask

  task t_irq;
    // Events left over from the pending test are cleared first
    wr(8'h28, 32'h7, 4'h1);
    rd(8'h28, 32'h0);
    wr(8'h2C, 32'h6, 4'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h08, 32'hFFFE, 4'h3);
    pulse(0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h28, 32'h1);
    wr(8'h2C, 32'h7, 4'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h28, 32'h1, 4'h1);
    rd(8'h28, 32'h0);
    cpu_dly <= 4'h0;
    cpu_en <= 1'b1;
    repeat (10) @(posedge pclk);
    cpu_en <= 1'b0;
    rd(8'h00, 32'h0);
    wr(8'h28, 32'h7, 4'h1);
    wr(8'h08, 32'hFFFF, 4'h3);
    $display("done irq");
  endtask

  task t_ext;
    wr(8'h18, 32'h1, 4'h1);
    ext_pin <= 6'h01;
    repeat (6) @(posedge pclk);
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h0, 4'h3);
    wr(8'h1C, 32'h2, 4'h1);
    // Pin 0 falls with only rise enabled, pin 1 rises with only fall enabled
    ext_pin <= 6'h02;
    repeat (6) @(posedge pclk);
    ext_pin <= 6'h00;
    repeat (6) @(posedge pclk);
    rd(8'h00, 32'h4);
    $display("done edges");
  endtask

  // A request while ce is low must not reach the flags
  task t_ce;
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    rd(8'h00, 32'h4);
    $display("done clock enable");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_src;
    t_bits;
    t_pend;
    t_irq;
    t_ext;
    t_ce;
    complete_run;
  end
endmodule

// ---- intfr_top_monitor.sv ----
// Purpose: Port checks of the flag block
// Assumes: ce high around accesses
// Notes: Bound to intfr_top
`timescale 1ns/100ps
`include "intfr_defs.svh"

module intfr_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_ack,
  input wire logic [`INTFR_IDX_W-1:0] cpu_ack_index,
  input wire intfr_pkg::intfr_pend_type intr_pend
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && $rose(penable) && ce;
  endsequence
  sequence s_read;
    pready && !pwrite;
  endsequence
  property p_wait;
    s_access |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_one;
    pready && ce |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h2C);
  endproperty
  a_map: assert property (p_map) else $error("error flag wrong for address");
  property p_err;
    (s_read and pslverr) |-> prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("refused read not zero");
  property p_high;
    (s_read and (paddr <= 8'h04)) |-> prdata[31:16] == 16'h0;
  endproperty
  a_high: assert property (p_high) else $error("flag word upper half set");
  property p_rsv;
    (s_read and (paddr == 8'h04)) |-> prdata[15:13] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused request bits set");
  property p_ack;
    cpu_ack |-> ##2 !(intr_pend.valid && intr_pend.index == $past(cpu_ack_index, 2));
  endproperty
  a_ack: assert property (p_ack) else $error("acked flag still pending");
  property p_idx;
    intr_pend.valid |-> intr_pend.index < 5'h1D;
  endproperty
  a_idx: assert property (p_idx) else $error("pending index out of range");
  property p_boot;
    $rose(presetn) |=> !intr_pend.valid;
  endproperty
  a_boot: assert property (p_boot) else $error("pending right after reset");
endmodule

bind intfr_top intfr_top_monitor u_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .cpu_ack, .cpu_ack_index, .intr_pend);
